// File: rtl/etd_map.svh
// Purpose: Offsets, widths and field positions of the ECC dual-port RAM
// Assumes: Included by the package and the top module
// Notes:   Definitions only
`ifndef ETD_MAP_SVH
`define ETD_MAP_SVH
`define ETD_DATA_W   8
`define ETD_CODE_W   13
`define ETD_ADDR_W   4
`define ETD_DEPTH    16
`define ETD_SYN_W    4
`define ETD_VLD_W    4
`define ETD_CNT_W    16
`define ETD_CNT_MAX  16'hFFFF
`define ETD_APB_AW   8
`define ETD_OFS_CTRL 8'h00
`define ETD_OFS_STAT 8'h04
`define ETD_OFS_CNTA 8'h08
`define ETD_OFS_CNTB 8'h0C
`define ETD_CTRL_INJ 0
`endif

// File: rtl/etd_pkg.sv
// Purpose: Types of the ECC dual-port RAM
// Assumes: etd_map.svh holds all numbers except the 32-bit APB data width
// Notes:   Carriers and state records only
`include "etd_map.svh"
package etd_pkg;

  typedef struct packed {
    logic [`ETD_ADDR_W-1:0] addr;
    logic [`ETD_DATA_W-1:0] data;
    logic                   wr;
    logic                   rd;
  } etd_req_type;

  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`ETD_APB_AW-1:0] paddr;
    logic [31:0]            pwdata;
  } etd_apb_type;

  typedef struct packed {
    logic [`ETD_CODE_W-1:0] code;
    logic [`ETD_ADDR_W-1:0] addr;
    logic                   wr;
    logic                   rd;
  } etd_stage_type;

  typedef struct packed {
    logic [`ETD_DATA_W-1:0] data;
    logic                   seen;
    logic                   fix;
    logic                   fatal;
  } etd_dec_type;

  typedef struct packed {
    etd_stage_type                             enc_a;
    etd_stage_type                             enc_b;
    etd_stage_type                             ram_a;
    etd_stage_type                             ram_b;
    logic [`ETD_CODE_W-1:0]                    q_a;
    logic [`ETD_CODE_W-1:0]                    q_b;
    logic [`ETD_DEPTH-1:0][`ETD_CODE_W-1:0]    mem;
    etd_dec_type                               dec_a;
    etd_dec_type                               dec_b;
  } etd_dp_type;

  typedef struct packed {
    logic [`ETD_VLD_W-1:0] vld_a;
    logic [`ETD_VLD_W-1:0] vld_b;
    logic                  ready;
    logic                  slverr;
    logic [31:0]           rdata;
    logic                  inject;
    logic [`ETD_CNT_W-1:0] fix_a;
    logic [`ETD_CNT_W-1:0] bad_a;
    logic [`ETD_CNT_W-1:0] fix_b;
    logic [`ETD_CNT_W-1:0] bad_b;
  } etd_ctl_type;

endpackage

// File: rtl/etd_ecc_dpram.sv
// Purpose: ECC protected 16 x 8 true dual-port RAM with APB status
// Assumes: All inputs come from logic on ref_clk
// Notes:   SECDED code, four cycle read latency per port
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "etd_map.svh"
module etd_ecc_dpram (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire etd_pkg::etd_req_type   port_a_req,
  input  wire etd_pkg::etd_req_type   port_b_req,
  input  wire logic                   port_a_lsb_fault_inject,
  input  wire etd_pkg::etd_apb_type   apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [`ETD_DATA_W-1:0]      port_a_decoded_word,
  output logic                        port_a_fault_seen,
  output logic                        port_a_fix_applied,
  output logic                        port_a_uncorrectable,
  output logic                        port_a_read_valid,
  output logic [`ETD_DATA_W-1:0]      port_b_decoded_word,
  output logic                        port_b_fault_seen,
  output logic                        port_b_fix_applied,
  output logic                        port_b_uncorrectable,
  output logic                        port_b_read_valid
);

  // ----------------------------------------------------------------
  // Code functions
  // ----------------------------------------------------------------
  // Hamming positions 1..12, overall parity in bit 0
  function automatic logic [`ETD_CODE_W-1:0] etd_encode(
    input logic [`ETD_DATA_W-1:0] d
  );
    logic [`ETD_CODE_W-1:0] c;
    c     = '0;
    c[3]  = d[0];
    c[5]  = d[1];
    c[6]  = d[2];
    c[7]  = d[3];
    c[9]  = d[4];
    c[10] = d[5];
    c[11] = d[6];
    c[12] = d[7];
    c[1]  = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    c[2]  = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    c[4]  = c[5] ^ c[6] ^ c[7] ^ c[12];
    c[8]  = c[9] ^ c[10] ^ c[11] ^ c[12];
    c[0]  = ^c[12:1];
    return c;
  endfunction

  function automatic etd_pkg::etd_dec_type etd_decode(
    input logic [`ETD_CODE_W-1:0] c
  );
    etd_pkg::etd_dec_type   r;
    logic [`ETD_SYN_W-1:0]  syn;
    logic [`ETD_CODE_W-1:0] fixed;
    logic                   par;
    r     = '0;
    syn   = '0;
    fixed = c;
    par   = ^c;
    for (int p = 1; p < `ETD_CODE_W; p++)
    begin
      if (c[p])
      begin
        syn = syn ^ `ETD_SYN_W'(p);
      end
    end
    if (par)
    begin
      r.seen = 1'b1;
      if (syn < `ETD_SYN_W'(`ETD_CODE_W))
      begin
        fixed[syn] = ~fixed[syn];
        r.fix      = 1'b1;
      end
      else
      begin
        r.fatal = 1'b1;
      end
    end
    else if (syn != '0)
    begin
      r.seen  = 1'b1;
      r.fatal = 1'b1;
    end
    r.data = {fixed[12:9], fixed[7:5], fixed[3]};
    return r;
  endfunction

  // Saturating counter, an event in a clearing cycle counts after the clear, leaving one
  function automatic logic [`ETD_CNT_W-1:0] etd_bump(
    input logic [`ETD_CNT_W-1:0] cnt,
    input logic                  clr,
    input logic                  inc
  );
    logic [`ETD_CNT_W-1:0] b;
    b = clr ? '0 : cnt;
    if (inc && b != `ETD_CNT_MAX)
    begin
      b = b + `ETD_CNT_W'(1);
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  etd_pkg::etd_dp_type  dp;
  etd_pkg::etd_dp_type  next_dp;
  etd_pkg::etd_ctl_type ctl;
  etd_pkg::etd_ctl_type next_ctl;

  always_comb
  begin
    next_dp = dp;
    // Encoder stage, side signals matched
    next_dp.enc_a.code = etd_encode(port_a_req.data);
    next_dp.enc_b.code = etd_encode(port_b_req.data);
    next_dp.enc_a.code[0] = next_dp.enc_a.code[0]
                            ^ (port_a_lsb_fault_inject
                               | ctl.inject);
    next_dp.enc_a.addr = port_a_req.addr;
    next_dp.enc_a.wr   = port_a_req.wr;
    next_dp.enc_a.rd   = port_a_req.rd;
    next_dp.enc_b.addr = port_b_req.addr;
    next_dp.enc_b.wr   = port_b_req.wr;
    next_dp.enc_b.rd   = port_b_req.rd;
    // Memory input registers
    next_dp.ram_a = dp.enc_a;
    next_dp.ram_b = dp.enc_b;
    // Reads see the array before this edge's writes, except a port A read with write, which returns its own write word
    if (dp.ram_a.rd)
    begin
      if (dp.ram_a.wr)
      begin
        next_dp.q_a = dp.ram_a.code;
      end
      else
      begin
        next_dp.q_a = dp.mem[dp.ram_a.addr];
      end
    end
    if (dp.ram_b.rd)
    begin
      next_dp.q_b = dp.mem[dp.ram_b.addr];
    end
    // Whole word writes, port A last on contention
    if (dp.ram_b.wr)
    begin
      next_dp.mem[dp.ram_b.addr] = dp.ram_b.code;
    end
    if (dp.ram_a.wr)
    begin
      next_dp.mem[dp.ram_a.addr] = dp.ram_a.code;
    end
    // Decoder stage, stored word left as is
    next_dp.dec_a = etd_decode(dp.q_a);
    next_dp.dec_b = etd_decode(dp.q_b);
  end

  // No clear on any datapath register; only q_a, q_b (rd) and mem (wr) have an enable
  always_ff @(posedge ref_clk)
  begin
    dp <= next_dp;
  end

  // ----------------------------------------------------------------
  // Read tracking, counters and APB slave
  // ----------------------------------------------------------------
  logic        apb_acc;
  logic        apb_done;
  logic        apb_wr;
  logic        clr_a;
  logic        clr_b;
  logic [31:0] rd_mux;
  logic        rd_miss;

  always_comb
  begin
    apb_acc  = apb_req.psel & apb_req.penable;
    apb_done = apb_acc & ctl.ready;
    apb_wr   = apb_done & apb_req.pwrite;
    rd_miss  = 1'b0;
    rd_mux   = '0;
    unique case (apb_req.paddr)
      `ETD_OFS_CTRL:
      begin
        rd_mux[`ETD_CTRL_INJ] = ctl.inject;
      end
      `ETD_OFS_STAT:
      begin
        rd_mux[5:0] = {dp.dec_b.fatal, dp.dec_b.fix, dp.dec_b.seen,
                       dp.dec_a.fatal, dp.dec_a.fix, dp.dec_a.seen};
      end
      `ETD_OFS_CNTA:
      begin
        rd_mux = {ctl.bad_a, ctl.fix_a};
      end
      `ETD_OFS_CNTB:
      begin
        rd_mux = {ctl.bad_b, ctl.fix_b};
      end
      default:
      begin
        rd_miss = 1'b1;
      end
    endcase
    clr_a = apb_wr & (apb_req.paddr == `ETD_OFS_CNTA);
    clr_b = apb_wr & (apb_req.paddr == `ETD_OFS_CNTB);
  end

  always_comb
  begin
    next_ctl = ctl;
    // Read enable follows the four register stages
    next_ctl.vld_a = {ctl.vld_a[`ETD_VLD_W-2:0], port_a_req.rd};
    next_ctl.vld_b = {ctl.vld_b[`ETD_VLD_W-2:0], port_b_req.rd};
    next_ctl.fix_a = etd_bump(ctl.fix_a, clr_a,
                              ctl.vld_a[`ETD_VLD_W-1] & dp.dec_a.fix);
    next_ctl.bad_a = etd_bump(ctl.bad_a, clr_a,
                              ctl.vld_a[`ETD_VLD_W-1] & dp.dec_a.fatal);
    next_ctl.fix_b = etd_bump(ctl.fix_b, clr_b,
                              ctl.vld_b[`ETD_VLD_W-1] & dp.dec_b.fix);
    next_ctl.bad_b = etd_bump(ctl.bad_b, clr_b,
                              ctl.vld_b[`ETD_VLD_W-1] & dp.dec_b.fatal);
    // One wait state, answer stands with pready only
    next_ctl.ready  = apb_acc & ~ctl.ready;
    next_ctl.rdata  = '0;
    next_ctl.slverr = 1'b0;
    if (apb_acc && !ctl.ready)
    begin
      next_ctl.slverr = rd_miss;
      if (!apb_req.pwrite)
      begin
        next_ctl.rdata = rd_mux;
      end
    end
    if (apb_wr && apb_req.paddr == `ETD_OFS_CTRL)
    begin
      next_ctl.inject = apb_req.pwdata[`ETD_CTRL_INJ];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl <= '0;
    end
    else
    begin
      ctl <= next_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata               = ctl.rdata;
  assign pready               = ctl.ready;
  assign pslverr              = ctl.slverr;
  assign port_a_decoded_word  = dp.dec_a.data;
  assign port_a_fault_seen    = dp.dec_a.seen;
  assign port_a_fix_applied   = dp.dec_a.fix;
  assign port_a_uncorrectable = dp.dec_a.fatal;
  assign port_a_read_valid    = ctl.vld_a[`ETD_VLD_W-1];
  assign port_b_decoded_word  = dp.dec_b.data;
  assign port_b_fault_seen    = dp.dec_b.seen;
  assign port_b_fix_applied   = dp.dec_b.fix;
  assign port_b_uncorrectable = dp.dec_b.fatal;
  assign port_b_read_valid    = ctl.vld_b[`ETD_VLD_W-1];

endmodule // etd_ecc_dpram

// File: verif/etd_ecc_checker.sv
// Purpose: Port-level assertions for the ECC dual-port RAM
// Assumes: Bound to etd_ecc_dpram, one clock domain
// Notes:   Read answer four cycles after rd
`timescale 1ns/1ns
`include "etd_map.svh"
module etd_ecc_checker (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire etd_pkg::etd_req_type    port_a_req,
  input wire etd_pkg::etd_req_type    port_b_req,
  input wire logic                    port_a_lsb_fault_inject,
  input wire logic [`ETD_DATA_W-1:0]  port_a_decoded_word,
  input wire logic                    port_a_fault_seen,
  input wire logic                    port_a_fix_applied,
  input wire logic                    port_a_uncorrectable,
  input wire logic                    port_a_read_valid,
  input wire logic                    port_b_fault_seen,
  input wire logic                    port_b_fix_applied,
  input wire logic                    port_b_uncorrectable,
  input wire logic                    port_b_read_valid
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Port properties
  // ----------------------------------------------------------------
  sequence s_rdw_a;
    port_a_req.rd && port_a_req.wr && !port_a_lsb_fault_inject;
  endsequence
  sequence s_inj_a;
    port_a_req.rd && port_a_req.wr && port_a_lsb_fault_inject;
  endsequence
  property p_lat_a;
    port_a_req.rd |-> ##4 port_a_read_valid;
  endproperty
  property p_lat_b;
    port_b_req.rd |-> ##4 port_b_read_valid;
  endproperty
  property p_quiet_a;
    port_a_read_valid |-> $past(port_a_req.rd, 4);
  endproperty
  property p_quiet_b;
    port_b_read_valid |-> $past(port_b_req.rd, 4);
  endproperty
  property p_rdw_a;
    s_rdw_a |-> ##4 port_a_decoded_word == $past(port_a_req.data, 4);
  endproperty
  property p_inj_a;
    s_inj_a |-> ##4 port_a_fix_applied && port_a_fault_seen
      && port_a_decoded_word == $past(port_a_req.data, 4);
  endproperty
  property p_cls_a;
    port_a_read_valid |-> !(port_a_fix_applied && port_a_uncorrectable)
      && port_a_fault_seen == (port_a_fix_applied || port_a_uncorrectable);
  endproperty
  property p_cls_b;
    port_b_read_valid |-> !(port_b_fix_applied && port_b_uncorrectable)
      && port_b_fault_seen == (port_b_fix_applied || port_b_uncorrectable);
  endproperty
  a_lat_a: assert property (p_lat_a)
    else $error("port a answer late");
  a_lat_b: assert property (p_lat_b)
    else $error("port b answer late");
  a_quiet_a: assert property (p_quiet_a)
    else $error("port a answer without read");
  a_quiet_b: assert property (p_quiet_b)
    else $error("port b answer without read");
  a_rdw_a: assert property (p_rdw_a)
    else $error("port a did not return new data");
  a_inj_a: assert property (p_inj_a)
    else $error("port a injected flip not corrected");
  a_cls_a: assert property (p_cls_a)
    else $error("port a status flags inconsistent");
  a_cls_b: assert property (p_cls_b)
    else $error("port b status flags inconsistent");
endmodule // etd_ecc_checker

bind etd_ecc_dpram etd_ecc_checker u_chk (.ref_clk, .rst_n, .port_a_req,
  .port_b_req, .port_a_lsb_fault_inject, .port_a_decoded_word,
  .port_a_fault_seen, .port_a_fix_applied, .port_a_uncorrectable,
  .port_a_read_valid, .port_b_fault_seen, .port_b_fix_applied,
  .port_b_uncorrectable, .port_b_read_valid);

// File: verif/etd_user_model.sv
// Purpose: User logic driving both memory ports
// Assumes: Requests launched just after a rising edge
// Notes:   Idle cycles after a request show inverted address and data
`timescale 1ns/1ns
module etd_user_model (
  input  wire logic            ref_clk,
  output etd_pkg::etd_req_type port_a_req,
  output etd_pkg::etd_req_type port_b_req,
  output logic                 port_a_lsb_fault_inject
);
  initial
  begin
    port_a_req = '0;
    port_b_req = '0;
    port_a_lsb_fault_inject = 1'h0;
  end
  // One request cycle on both ports, then idle
  task automatic drive(etd_pkg::etd_req_type a, etd_pkg::etd_req_type b,
                       logic inj);
    if (a.wr && b.wr && a.addr == b.addr)
      b.wr = 1'h0;
    @(posedge ref_clk);
    port_a_req <= a;
    port_b_req <= b;
    port_a_lsb_fault_inject <= inj;
    @(posedge ref_clk);
    port_a_req <= '{~a.addr, ~a.data, 1'h0, 1'h0};
    port_b_req <= '{~b.addr, ~b.data, 1'h0, 1'h0};
    port_a_lsb_fault_inject <= ~inj;
  endtask
endmodule // etd_user_model

// File: verif/tb.sv
// Purpose: Self-checking bench for the ECC dual-port RAM
// Assumes: Checker bound from its own file
// Notes:   Port results packed as data, seen, fix, fatal, valid
`timescale 1ns/1ns
`include "etd_map.svh"
module tb;
  logic                 ref_clk = 1'h0;
  logic                 rst_n = 1'h0;
  etd_pkg::etd_req_type a_req;
  etd_pkg::etd_req_type b_req;
  logic                 inj;
  etd_pkg::etd_apb_type apb = '0;
  wire [32:0]           ap;
  wire                  pready;
  wire [11:0]           ra;
  wire [11:0]           rb;
  int                   fail_count = 0;
  int                   n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  etd_user_model u_user (.ref_clk(ref_clk), .port_a_req(a_req),
    .port_b_req(b_req), .port_a_lsb_fault_inject(inj));

  etd_ecc_dpram u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .port_a_req(a_req),
    .port_b_req(b_req), .port_a_lsb_fault_inject(inj), .apb_req(apb),
    .prdata(ap[31:0]), .pready(pready), .pslverr(ap[32]),
    .port_a_decoded_word(ra[11:4]), .port_a_fault_seen(ra[3]),
    .port_a_fix_applied(ra[2]), .port_a_uncorrectable(ra[1]),
    .port_a_read_valid(ra[0]), .port_b_decoded_word(rb[11:4]),
    .port_b_fault_seen(rb[3]), .port_b_fix_applied(rb[2]),
    .port_b_uncorrectable(rb[1]), .port_b_read_valid(rb[0]));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [11:0] r(logic [7:0] d, logic f);
    return {d, f, f, 1'h0, 1'h1};
  endfunction

  // Answer stands after the fourth edge from the request launch
  task automatic op(etd_pkg::etd_req_type a, etd_pkg::etd_req_type b,
                    logic i, logic [11:0] ea, logic [11:0] eb);
    u_user.drive(a, b, i);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    if (a.rd)
      cmp("port a", {21'h0, ea}, {21'h0, ra});
    if (b.rd)
      cmp("port b", {21'h0, eb}, {21'h0, rb});
  endtask

  task automatic apb_x(logic wr, logic [7:0] ad, logic [31:0] wd,
                       logic [32:0] e);
    int i;
    @(posedge ref_clk);
    apb <= '{1'h1, 1'h0, wr, ad, wd};
    @(posedge ref_clk);
    apb.penable <= 1'h1;
    @(negedge ref_clk);
    for (i = 0; i < 20 && pready !== 1'h1; i++)
      @(negedge ref_clk);
    if (i == 20)
      fail_count++;
    else
      cmp("apb", e, wr ? {ap[32], 32'h0} : ap);
    // Completing edge: pready sampled high here
    @(posedge ref_clk);
    apb <= '0;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    op('{4'h1, 8'hAA, 1'h1, 1'h0}, '{4'h2, 8'hBB, 1'h1, 1'h0}, 1'h0,
       12'h0, 12'h0);
    op('{4'h2, 8'h00, 1'h0, 1'h1}, '{4'h1, 8'h00, 1'h0, 1'h1}, 1'h0,
       r(8'hBB, 1'h0), r(8'hAA, 1'h0));
    op('{4'h1, 8'h5A, 1'h1, 1'h1}, '{4'h2, 8'hC3, 1'h1, 1'h1}, 1'h0,
       r(8'h5A, 1'h0), r(8'hBB, 1'h0));
    op('{4'h1, 8'h3C, 1'h1, 1'h0}, '{4'h1, 8'h00, 1'h0, 1'h1}, 1'h0,
       12'h0, r(8'h5A, 1'h0));
    op('{4'h0, 8'hFF, 1'h1, 1'h1}, '{4'h2, 8'h00, 1'h0, 1'h1}, 1'h1,
       r(8'hFF, 1'h1), r(8'hC3, 1'h0));
    op('{4'h0, 8'h00, 1'h0, 1'h1}, '{4'h1, 8'h00, 1'h0, 1'h1}, 1'h0,
       r(8'hFF, 1'h1), r(8'h3C, 1'h0));
    apb_x(1'h0, `ETD_OFS_CNTA, 32'h0, 33'h2);
    apb_x(1'h0, `ETD_OFS_STAT, 32'h0, 33'h3);
    apb_x(1'h1, `ETD_OFS_CNTA, 32'h0, 33'h0);
    apb_x(1'h0, `ETD_OFS_CNTA, 32'h0, 33'h0);
    apb_x(1'h1, `ETD_OFS_CTRL, 32'h1, 33'h0);
    apb_x(1'h0, `ETD_OFS_CTRL, 32'h0, 33'h1);
    op('{4'h6, 8'h77, 1'h1, 1'h1}, '{4'h6, 8'h00, 1'h0, 1'h0}, 1'h0,
       r(8'h77, 1'h1), 12'h0);
    apb_x(1'h1, `ETD_OFS_CTRL, 32'h0, 33'h0);
    apb_x(1'h0, `ETD_OFS_CNTA, 32'h0, 33'h1);
    op('{4'h0, 8'h00, 1'h0, 1'h0}, '{4'h0, 8'h00, 1'h0, 1'h1}, 1'h0,
       12'h0, r(8'hFF, 1'h1));
    apb_x(1'h0, `ETD_OFS_CNTB, 32'h0, 33'h1);
    apb_x(1'h0, 8'h10, 32'h0, {1'h1, 32'h0});
    tally_and_finish;
  end
endmodule // tb
